/* verilog/rvs_pkg.sv */
// Purpose: Shared constants and types for the regulator voltage setting bank
// Assumes: 10 MHz core clock, byte-wide registers
// Notes:   Reset values stand in for the factory-programmed defaults
package rvs_pkg;
    // Register offsets
    localparam logic [7:0] RVS_CH2_OFS     = 8'h0C;
    localparam logic [7:0] RVS_CH3_OFS     = 8'h0D;
    localparam logic [7:0] RVS_CH4_OFS     = 8'h0E;
    localparam logic [7:0] RVS_EXT_LDO_OFS = 8'h0F;

    // Field widths and positions
    localparam int RVS_CH2_W      = 5;
    localparam int RVS_CH3_W      = 4;
    localparam int RVS_CH4_W      = 5;
    localparam int RVS_THR_W      = 4;
    localparam int RVS_LDO_A_LSB  = 0;
    localparam int RVS_LDO_B_LSB  = 4;

    // Reset values and the highest channel 4 code
    localparam logic [4:0] RVS_CH2_RST   = 5'h06;
    localparam logic [3:0] RVS_CH3_RST   = 4'h6;
    localparam logic [4:0] RVS_CH4_RST   = 5'h10;
    localparam logic [4:0] RVS_CH4_MAX   = 5'h14;
    localparam logic [3:0] RVS_LDO_A_RST = 4'h0;
    localparam logic [3:0] RVS_LDO_B_RST = 4'h0;

    // Ramp dwell timing
    localparam int RVS_CLK_PERIOD_PS = 100000;
    localparam int RVS_STEP_SHORT_PS = 52500000;
    localparam int RVS_STEP_LONG_PS  = 105000000;
    localparam int RVS_STEP_SHORT_CYC = RVS_STEP_SHORT_PS / RVS_CLK_PERIOD_PS;
    localparam int RVS_STEP_LONG_CYC  = RVS_STEP_LONG_PS / RVS_CLK_PERIOD_PS;
    localparam int RVS_DWELL_W        = 11;

    // Ramp sequencer states
    typedef enum logic [0:0] {
        RVS_RAMP_IDLE = 1'b0,
        RVS_RAMP_WAIT = 1'b1
    } rvs_ramp_e;

    // Register access request from the serial interface
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rvs_req_s;
endpackage : rvs_pkg

/* verilog/rvs_regs.sv */
// Purpose: Voltage target registers for channels 2-4 and external LDO thresholds
// Assumes: Requests come from the serial slave on the same clock, one per cycle
// Notes:   Applied codes walk toward the targets one step per dwell period
//
// Functional notes
// - Channel 2 code is five bits, 3.00 V plus 50 mV per step.
// - Channel 2 register at 0x0C, bits 4:0, resets to code 00110.
// - Channel 3 code is four bits in 3:0, 3.00 V plus 50 mV steps.
// - Channel 3 register at 0x0D, readable and writable.
// - Channel 4 code five bits, 3.20 V base, codes above 10100 reserved.
// - Channel 4 register at 0x0E, resets to code 10000.
// - Upper nibble of threshold register sets second monitor level, default 0000.
// - Threshold register at 0x0F holds both monitor fields.
// - Both threshold fields set rising power-good assertion level.
// - Code changes ramp one step per 52.5 us, or 105 us when selected.
`timescale 1ns/1ps
module rvs_regs
    import rvs_pkg::*;
#(
    parameter logic [3:0] CH3_DEFAULT = RVS_CH3_RST,
    parameter int         STEP_SHORT  = RVS_STEP_SHORT_CYC,
    parameter int         STEP_LONG   = RVS_STEP_LONG_CYC
) (
    input  wire logic                 I_MCLK,
    input  wire logic                 I_RST_B,
    input  wire rvs_req_s             I_REQ,
    input  wire logic                 I_RAMP_STEP_TIME_SEL,
    output logic [7:0]                O_RDATA,
    output logic                      O_RVALID,
    output logic [RVS_CH2_W-1:0]      O_CH2_VOLTAGE_CODE,
    output logic [RVS_CH3_W-1:0]      O_CH3_VOLTAGE_CODE,
    output logic [RVS_CH4_W-1:0]      O_CH4_VOLTAGE_CODE,
    output logic                      O_RAMP_BUSY,
    output logic [RVS_THR_W-1:0]      O_EXT_LDO_A_THRESHOLD,
    output logic [RVS_THR_W-1:0]      O_EXT_LDO_B_THRESHOLD
);

    // Dwell counts must fit the shared timer, refused at elaboration
    if (STEP_SHORT < 1 || STEP_LONG < 1 || STEP_SHORT >= 2**RVS_DWELL_W || STEP_LONG >= 2**RVS_DWELL_W) begin : g_bad_dwell
        $error("rvs_regs: dwell counts out of range");
    end

    // One step of an applied code toward its target
    function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] tgt);
        if (cur < tgt) begin
            step_toward = cur + 5'h01;
        end else if (cur > tgt) begin
            step_toward = cur - 5'h01;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // Target registers
    logic [4:0] ch2_tgt_q, ch2_tgt_d;
    logic [3:0] ch3_tgt_q, ch3_tgt_d;
    logic [4:0] ch4_tgt_q, ch4_tgt_d;
    logic [3:0] ldo_a_q, ldo_a_d;
    logic [3:0] ldo_b_q, ldo_b_d;
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    // Register writes and registered read data
    always_comb begin
        ch2_tgt_d = ch2_tgt_q;
        ch3_tgt_d = ch3_tgt_q;
        ch4_tgt_d = ch4_tgt_q;
        ldo_a_d   = ldo_a_q;
        ldo_b_d   = ldo_b_q;
        rdata_d   = rdata_q;
        rvalid_d  = I_REQ.rd_en;
        if (I_REQ.wr_en) begin
            if (I_REQ.addr == RVS_CH2_OFS) begin
                ch2_tgt_d = I_REQ.wdata[RVS_CH2_W-1:0];
            end else if (I_REQ.addr == RVS_CH3_OFS) begin
                ch3_tgt_d = I_REQ.wdata[RVS_CH3_W-1:0];
            end else if (I_REQ.addr == RVS_CH4_OFS) begin
                ch4_tgt_d = I_REQ.wdata[RVS_CH4_W-1:0];
            end else if (I_REQ.addr == RVS_EXT_LDO_OFS) begin
                ldo_a_d = I_REQ.wdata[RVS_LDO_A_LSB +: RVS_THR_W];
                ldo_b_d = I_REQ.wdata[RVS_LDO_B_LSB +: RVS_THR_W];
            end
        end
        if (I_REQ.rd_en) begin
            if (I_REQ.addr == RVS_CH2_OFS) begin
                rdata_d = {3'h0, ch2_tgt_q};
            end else if (I_REQ.addr == RVS_CH3_OFS) begin
                rdata_d = {4'h0, ch3_tgt_q};
            end else if (I_REQ.addr == RVS_CH4_OFS) begin
                rdata_d = {3'h0, ch4_tgt_q};
            end else if (I_REQ.addr == RVS_EXT_LDO_OFS) begin
                rdata_d = {ldo_b_q, ldo_a_q};
            end else begin
                rdata_d = 8'h00; // Unmapped reads return zero
            end
        end
    end

    // Defaults stand in for programmed values after power-up
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ch2_tgt_q <= RVS_CH2_RST;
            ch3_tgt_q <= CH3_DEFAULT;
            ch4_tgt_q <= RVS_CH4_RST;
            ldo_a_q   <= RVS_LDO_A_RST;
            ldo_b_q   <= RVS_LDO_B_RST;
            rdata_q   <= 8'h00;
            rvalid_q  <= 1'b0;
        end else begin
            ch2_tgt_q <= ch2_tgt_d;
            ch3_tgt_q <= ch3_tgt_d;
            ch4_tgt_q <= ch4_tgt_d;
            ldo_a_q   <= ldo_a_d;
            ldo_b_q   <= ldo_b_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
        end
    end

    // Ramp state: one shared dwell timer steps every lagging channel together
    rvs_ramp_e                ramp_q, ramp_d;
    logic [RVS_DWELL_W-1:0]   dwell_q, dwell_d;
    logic [4:0]               ch2_cur_q, ch2_cur_d;
    logic [4:0]               ch3_cur_q, ch3_cur_d;
    logic [4:0]               ch4_cur_q, ch4_cur_d;
    logic [RVS_DWELL_W-1:0]   dwell_last;
    logic                     lagging;
    logic                     step_now;

    assign dwell_last = I_RAMP_STEP_TIME_SEL ? RVS_DWELL_W'(STEP_LONG - 1) : RVS_DWELL_W'(STEP_SHORT - 1);
    assign lagging    = (ch2_cur_q != ch2_tgt_q) || (ch3_cur_q != {1'b0, ch3_tgt_q}) || (ch4_cur_q != ch4_tgt_q);
    assign step_now   = (ramp_q == RVS_RAMP_WAIT) && (dwell_q == dwell_last);

    always_comb begin
        ramp_d    = ramp_q;
        dwell_d   = dwell_q;
        ch2_cur_d = ch2_cur_q;
        ch3_cur_d = ch3_cur_q;
        ch4_cur_d = ch4_cur_q;
        case (ramp_q)
            RVS_RAMP_IDLE: begin
                dwell_d = '0;
                if (lagging) begin
                    ramp_d = RVS_RAMP_WAIT;
                end
            end
            RVS_RAMP_WAIT: begin
                if (!lagging) begin
                    ramp_d  = RVS_RAMP_IDLE;
                    dwell_d = '0;
                end else if (step_now) begin
                    dwell_d   = '0;
                    ch2_cur_d = step_toward(ch2_cur_q, ch2_tgt_q);
                    ch3_cur_d = step_toward(ch3_cur_q, {1'b0, ch3_tgt_q});
                    ch4_cur_d = step_toward(ch4_cur_q, ch4_tgt_q);
                end else if (dwell_q > dwell_last) begin
                    dwell_d = '0; // Dwell shortened mid-count
                end else begin
                    dwell_d = dwell_q + 1'b1;
                end
            end
            default: begin
                ramp_d = RVS_RAMP_IDLE;
            end
        endcase
    end

    // Applied codes start equal to the defaults, so no ramp after reset
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ramp_q    <= RVS_RAMP_IDLE;
            dwell_q   <= '0;
            ch2_cur_q <= RVS_CH2_RST;
            ch3_cur_q <= {1'b0, CH3_DEFAULT};
            ch4_cur_q <= RVS_CH4_RST;
        end else begin
            ramp_q    <= ramp_d;
            dwell_q   <= dwell_d;
            ch2_cur_q <= ch2_cur_d;
            ch3_cur_q <= ch3_cur_d;
            ch4_cur_q <= ch4_cur_d;
        end
    end

    // Outputs toward the analog side
    assign O_RDATA            = rdata_q;
    assign O_RVALID           = rvalid_q;
    assign O_CH2_VOLTAGE_CODE = ch2_cur_q;
    assign O_CH3_VOLTAGE_CODE = ch3_cur_q[3:0];
    assign O_CH4_VOLTAGE_CODE = ch4_cur_q;
    assign O_RAMP_BUSY        = ramp_q == RVS_RAMP_WAIT;
    assign O_EXT_LDO_A_THRESHOLD = ldo_a_q;
    assign O_EXT_LDO_B_THRESHOLD = ldo_b_q;

    // Checks
    property p_ch2_store;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.wr_en && I_REQ.addr == RVS_CH2_OFS) |=> (ch2_tgt_q == $past(I_REQ.wdata[4:0]));
    endproperty
    a_ch2_store: assert property (p_ch2_store) else $error("ch2 code not stored");

    property p_ch2_read;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.rd_en && I_REQ.addr == RVS_CH2_OFS) |=> (O_RVALID && O_RDATA == {3'h0, $past(ch2_tgt_q)});
    endproperty
    a_ch2_read: assert property (p_ch2_read) else $error("ch2 readback wrong");

    property p_ch3_store;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.wr_en && I_REQ.addr == RVS_CH3_OFS) |=> (ch3_tgt_q == $past(I_REQ.wdata[3:0]));
    endproperty
    a_ch3_store: assert property (p_ch3_store) else $error("ch3 code not stored");

    property p_ch3_read;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.rd_en && I_REQ.addr == RVS_CH3_OFS) |=> (O_RDATA == {4'h0, $past(ch3_tgt_q)});
    endproperty
    a_ch3_read: assert property (p_ch3_read) else $error("ch3 readback wrong");

    property p_ch4_store;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.wr_en && I_REQ.addr == RVS_CH4_OFS) |=> (ch4_tgt_q == $past(I_REQ.wdata[4:0]));
    endproperty
    a_ch4_store: assert property (p_ch4_store) else $error("ch4 code not stored");

    property p_ch4_read;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.rd_en && I_REQ.addr == RVS_CH4_OFS) |=> (O_RDATA == {3'h0, $past(ch4_tgt_q)});
    endproperty
    a_ch4_read: assert property (p_ch4_read) else $error("ch4 readback wrong");

    property p_ldo_b;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.wr_en && I_REQ.addr == RVS_EXT_LDO_OFS) |=> (O_EXT_LDO_B_THRESHOLD == $past(I_REQ.wdata[7:4]));
    endproperty
    a_ldo_b: assert property (p_ldo_b) else $error("monitor B level wrong");

    property p_ldo_read;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.rd_en && I_REQ.addr == RVS_EXT_LDO_OFS) |=>
            (O_RDATA == {$past(O_EXT_LDO_B_THRESHOLD), $past(O_EXT_LDO_A_THRESHOLD)});
    endproperty
    a_ldo_read: assert property (p_ldo_read) else $error("threshold readback wrong");

    property p_ldo_a;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_REQ.wr_en && I_REQ.addr == RVS_EXT_LDO_OFS) |=> (O_EXT_LDO_A_THRESHOLD == $past(I_REQ.wdata[3:0]));
    endproperty
    a_ldo_a: assert property (p_ldo_a) else $error("monitor A level wrong");

    sequence s_code_moves;
        (O_CH2_VOLTAGE_CODE != $past(O_CH2_VOLTAGE_CODE));
    endsequence
    property p_ramp_step;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        s_code_moves |-> ($past(step_now) &&
            ((O_CH2_VOLTAGE_CODE == $past(O_CH2_VOLTAGE_CODE) + 5'h01) ||
             (O_CH2_VOLTAGE_CODE == $past(O_CH2_VOLTAGE_CODE) - 5'h01)));
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step not single");

    // dwell observer
    // Counts cycles between applied-code moves on its own, so a broken dwell timer shows up
    logic [13:0]            codes_seen_q, codes_seen_d;
    logic [RVS_DWELL_W-1:0] hold_q, hold_d;
    logic                   sel_seen_q, sel_seen_d;
    logic                   sel_mix_q, sel_mix_d;
    logic                   codes_moved;
    logic [RVS_DWELL_W-1:0] dwell_exp;

    assign codes_moved = {O_CH2_VOLTAGE_CODE, O_CH3_VOLTAGE_CODE, O_CH4_VOLTAGE_CODE} != codes_seen_q;
    assign dwell_exp   = sel_seen_q ? RVS_DWELL_W'(STEP_LONG) : RVS_DWELL_W'(STEP_SHORT);

    // Observer next state; a select change wins over a clear, so that dwell is skipped
    always_comb begin
        codes_seen_d = {O_CH2_VOLTAGE_CODE, O_CH3_VOLTAGE_CODE, O_CH4_VOLTAGE_CODE};
        sel_seen_d   = I_RAMP_STEP_TIME_SEL;
        hold_d       = (hold_q == '1) ? hold_q : hold_q + 1'b1;
        sel_mix_d    = sel_mix_q;
        if (!O_RAMP_BUSY) begin
            hold_d    = '0;
            sel_mix_d = 1'b0;
        end else if (codes_moved) begin
            hold_d    = RVS_DWELL_W'(1);
            sel_mix_d = 1'b0;
        end
        if (I_RAMP_STEP_TIME_SEL != sel_seen_q) begin
            sel_mix_d = 1'b1;
        end
    end

    // Observer registers
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            codes_seen_q <= {RVS_CH2_RST, CH3_DEFAULT, RVS_CH4_RST};
            hold_q       <= '0;
            sel_seen_q   <= 1'b0;
            sel_mix_q    <= 1'b1;
        end else begin
            codes_seen_q <= codes_seen_d;
            hold_q       <= hold_d;
            sel_seen_q   <= sel_seen_d;
            sel_mix_q    <= sel_mix_d;
        end
    end

    sequence s_any_move;
        codes_moved && !sel_mix_q;
    endsequence
    property p_dwell_len;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        s_any_move |-> (hold_q == dwell_exp);
    endproperty
    a_dwell_len: assert property (p_dwell_len) else $error("dwell between steps wrong");

endmodule : rvs_regs

/* testbench/rvs_host_model.sv */
// Purpose: Host-side model that issues register requests to the voltage bank
// Assumes: One request per task call, driven just after the rising edge
// Notes:   Reserved channel 4 codes are never sent
`timescale 1ns/1ps
module rvs_host_model
    import rvs_pkg::*;
(
    input  wire logic       i_clk,
    output rvs_req_s        o_req,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid
);
    // Idle request at time zero
    initial begin
        o_req = '0;
    end

    // One-cycle write pulse, data held for that cycle only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == RVS_CH4_OFS && d[4:0] > RVS_CH4_MAX) begin
            return;
        end
        @(posedge i_clk);
        o_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    // Read pulse, answer taken one cycle later while it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        o_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'hA5};
        @(posedge i_clk);
        o_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'h5A};
        @(negedge i_clk);
        d = i_rdata;
        v = i_rvalid;
    endtask : rd
endmodule : rvs_host_model

/* testbench/regulator_voltage_setting_regs_tb.sv */
// Purpose: Self-checking bench for the regulator voltage setting bank
// Assumes: Dwell counts shortened to 4 and 8 cycles
// Notes:   Expectations come from the field layout, never from the design
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module regulator_voltage_setting_regs_tb;
    import rvs_pkg::*;
    localparam int SHORT = 4;
    localparam int LONG  = 8;
    logic                 I_MCLK;
    logic                 I_RST_B;
    logic                 sel;
    rvs_req_s             req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [RVS_CH2_W-1:0] ch2;
    logic [RVS_CH3_W-1:0] ch3;
    logic [RVS_CH4_W-1:0] ch4;
    logic                 busy;
    logic [3:0]           thr_a;
    logic [3:0]           thr_b;
    int                   failures;
    int                   n_tests;

    rvs_regs #(.CH3_DEFAULT(RVS_CH3_RST), .STEP_SHORT(SHORT), .STEP_LONG(LONG)) u_dut (
        .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_REQ(req), .I_RAMP_STEP_TIME_SEL(sel),
        .O_RDATA(rdata), .O_RVALID(rvalid), .O_CH2_VOLTAGE_CODE(ch2), .O_CH3_VOLTAGE_CODE(ch3),
        .O_CH4_VOLTAGE_CODE(ch4), .O_RAMP_BUSY(busy), .O_EXT_LDO_A_THRESHOLD(thr_a),
        .O_EXT_LDO_B_THRESHOLD(thr_b));
    rvs_host_model u_host (.i_clk(I_MCLK), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

    // Clock at 10 MHz
    initial begin
        I_MCLK = 1'b0;
        forever #50 I_MCLK = ~I_MCLK;
    end

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Read one register and compare data and the valid pulse
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        logic       v;
        u_host.rd(a, d, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", ex, d)
    endtask : rd_chk

    // Bounded wait for the ramp to settle
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 600) begin
            @(negedge I_MCLK);
            n++;
        end
        `CHK("ramp settles", 1'b0, busy)
    endtask : wait_idle

    // Cycles between two successive steps of a code
    task automatic step_gap(input int ch, output int n);
        logic [4:0] prev;
        prev = (ch == 2) ? ch2 : {1'b0, ch3};
        n = 0;
        while (((ch == 2) ? ch2 : {1'b0, ch3}) === prev && n < 50) begin
            @(negedge I_MCLK);
            n++;
        end
    endtask : step_gap

    task automatic t_reset();
        rd_chk(RVS_CH2_OFS, 8'h06);
        rd_chk(RVS_CH3_OFS, 8'h06);
        rd_chk(RVS_CH4_OFS, 8'h10);
        rd_chk(RVS_EXT_LDO_OFS, 8'h00);
        `CHK("ch2 applied", 5'h06, ch2)
        `CHK("ch4 applied", 5'h10, ch4)
        `CHK("thr b", 4'h0, thr_b)
    endtask : t_reset

    task automatic t_ramp();
        int n;
        @(posedge I_MCLK);
        sel <= 1'b0;
        u_host.wr(RVS_CH2_OFS, 8'h08);
        step_gap(2, n);
        `CHK("ch2 first step", 5'h07, ch2)
        step_gap(2, n);
        `CHK("short dwell", SHORT, n)
        `CHK("ch2 second step", 5'h08, ch2)
        wait_idle();
        @(posedge I_MCLK);
        sel <= 1'b1;
        u_host.wr(RVS_CH3_OFS, 8'h04);
        step_gap(3, n);
        `CHK("ch3 first step", 4'h5, ch3)
        step_gap(3, n);
        `CHK("long dwell", LONG, n)
        `CHK("ch4 untouched", 5'h10, ch4)
        wait_idle();
    endtask : t_ramp

    task automatic t_fields();
        u_host.wr(RVS_CH2_OFS, 8'hFF);
        rd_chk(RVS_CH2_OFS, 8'h1F);
        u_host.wr(RVS_CH3_OFS, 8'hFF);
        rd_chk(RVS_CH3_OFS, 8'h0F);
        u_host.wr(RVS_CH4_OFS, 8'hF4);
        rd_chk(RVS_CH4_OFS, 8'h14);
        u_host.wr(RVS_EXT_LDO_OFS, 8'hA5);
        rd_chk(RVS_EXT_LDO_OFS, 8'hA5);
        `CHK("thr b field", 4'hA, thr_b)
        `CHK("thr a field", 4'h5, thr_a)
        u_host.wr(8'h10, 8'h33);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h0B, 8'h00);
        wait_idle();
        `CHK("ch2 final", 5'h1F, ch2)
        `CHK("ch3 final", 4'hF, ch3)
        `CHK("ch4 final", 5'h14, ch4)
    endtask : t_fields

    // Watchdog well beyond the longest ramp
    initial begin
        repeat (20000) @(posedge I_MCLK);
        failures++;
        final_report();
    end

    // Main sequence
    initial begin
        failures = 0;
        n_tests  = 0;
        sel      = 1'b0;
        I_RST_B  = 1'b0;
        repeat (2) @(posedge I_MCLK);
        I_RST_B <= 1'b1;
        t_reset();
        t_ramp();
        t_fields();
        final_report();
    end
endmodule : regulator_voltage_setting_regs_tb
